/* File: rtl/dag_unit.sv */
// one data address generator with primary and secondary banks
// assumes decoder holds op for one cycle per access
`timescale 1ns/10ps
`include "dag_cfg.svh"
module dag_unit (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic bank_sel,
    input wire dag_pkg::dag_op_t op,
    input wire logic [`DAG_SEL_W-1:0] idx_sel,
    input wire logic [`DAG_SEL_W-1:0] mod_sel,
    input wire logic [`DAG_IMM_W-1:0] imm,
    input wire dag_pkg::dag_wr_t wr_kind,
    input wire logic [`DAG_SEL_W-1:0] wr_sel,
    input wire logic [`DAG_PTR_W-1:0] wr_data,
    output logic [`DAG_PAGE_W+`DAG_PTR_W-1:0] addr,
    output logic addr_valid
);
    import dag_pkg::*;
    localparam int W = `DAG_PTR_W;
    localparam int N = `DAG_NREG;

    // ------------------------------------------------------------
    // register banks, index 0 primary and 1 secondary
    // ------------------------------------------------------------
    logic [W-1:0] index_r [2][N];
    logic [W-1:0] modify_r [2][N];
    logic [W-1:0] length_r [2][N];
    logic [W-1:0] base_r [2][N];
    logic [`DAG_PAGE_W-1:0] data_page_register [2];

    // wrap in 17 bits so a carry out of the pointer is seen
    // rather than silently folded into the page
    function automatic logic [W-1:0] wrap(input logic [W-1:0] p,
        input logic [W-1:0] off, input logic [W-1:0] len,
        input logic [W-1:0] bas);
        logic [W:0] sum;
        logic [W:0] top;
        sum = {1'b0, p} + {1'b0, off};
        top = {1'b0, bas} + {1'b0, len};
        if (len == `DAG_ZERO16) begin
            wrap = sum[W-1:0];
        end else if (off[W-1] == 1'b0 && sum >= top) begin
            wrap = W'(sum - {1'b0, len});
        end else if (off[W-1] == 1'b1 && W'(sum) < bas) begin
            wrap = W'(sum + {1'b0, len});
        end else begin
            wrap = sum[W-1:0];
        end
    endfunction : wrap

    logic [W-1:0] ptr;
    logic [W-1:0] offset;
    logic [W-1:0] updated;
    logic use_imm;
    logic is_pre;
    logic do_update;

    always_comb begin
        ptr = index_r[bank_sel][idx_sel];
        use_imm = (op == DAG_OP_POST_IMM) || (op == DAG_OP_PRE_IMM);
        is_pre = (op == DAG_OP_PRE_MOD) || (op == DAG_OP_PRE_NOUPD) ||
                 (op == DAG_OP_PRE_IMM);
        do_update = (op != DAG_OP_NONE) && (op != DAG_OP_PRE_NOUPD);
        offset = use_imm ? {{(W-`DAG_IMM_W){imm[`DAG_IMM_W-1]}}, imm}
                         : modify_r[bank_sel][mod_sel];
        updated = wrap(ptr, offset, length_r[bank_sel][idx_sel],
                       base_r[bank_sel][idx_sel]);
    end

    // ------------------------------------------------------------
    // address output
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            addr <= '0;
            addr_valid <= 1'b0;
        end else begin
            addr_valid <= (op != DAG_OP_NONE);
            // page bits come straight from the page register
            addr <= {data_page_register[bank_sel],
                     is_pre ? updated : ptr};
        end
    end

    // ------------------------------------------------------------
    // register updates; an access update wins over a write
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int b = 0; b < 2; b++) begin
                data_page_register[b] <= `DAG_ZERO8;
                for (int i = 0; i < N; i++) begin
                    index_r[b][i] <= `DAG_ZERO16;
                    modify_r[b][i] <= `DAG_ZERO16;
                    length_r[b][i] <= `DAG_ZERO16;
                    base_r[b][i] <= `DAG_ZERO16;
                end
            end
        end else begin
            unique case (wr_kind)
                DAG_WR_NONE: ;
                DAG_WR_INDEX: index_r[bank_sel][wr_sel] <= wr_data;
                DAG_WR_MODIFY: modify_r[bank_sel][wr_sel] <= wr_data;
                DAG_WR_LENGTH: length_r[bank_sel][wr_sel] <= wr_data;
                DAG_WR_BASE: base_r[bank_sel][wr_sel] <= wr_data;
                DAG_WR_PAGE: data_page_register[bank_sel] <=
                    wr_data[`DAG_PAGE_W-1:0];
                default: ;
            endcase
            if (do_update) begin
                index_r[bank_sel][idx_sel] <= updated;
            end
        end
    end
endmodule : dag_unit

/* File: rtl/dag_cfg.svh */
// constants for the dual data address generator
// assumes inclusion by dag_pkg and the generator modules
// Notes on behaviour
// - four 16-bit pointers per generator
// - pointer adjusted by selected modify register
// - length and base give circular buffers
// - pre-modify with no update keeps pointer
// - signed 8-bit immediate offset, sign extended
// - both generators address in one cycle
// - 8-bit page forms upper address bits
// - wrap never touches page bits
// - secondary register set, fast switch
`ifndef DAG_CFG_SVH
`define DAG_CFG_SVH
`define DAG_PTR_W 16
`define DAG_PAGE_W 8
`define DAG_IMM_W 8
`define DAG_NREG 4
`define DAG_SEL_W 2
`define DAG_ZERO16 16'h0000
`define DAG_ZERO8 8'h00
`endif

/* File: rtl/dag_pkg.sv */
// types for the dual data address generator
// assumes dag_cfg.svh on the include path
`include "dag_cfg.svh"
package dag_pkg;
    // ------------------------------------------------------------
    // operation and register-write selectors
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        DAG_OP_NONE,
        DAG_OP_POST_MOD,
        DAG_OP_PRE_MOD,
        DAG_OP_PRE_NOUPD,
        DAG_OP_POST_IMM,
        DAG_OP_PRE_IMM
    } dag_op_t;
    typedef enum logic [2:0] {
        DAG_WR_NONE,
        DAG_WR_INDEX,
        DAG_WR_MODIFY,
        DAG_WR_LENGTH,
        DAG_WR_BASE,
        DAG_WR_PAGE
    } dag_wr_t;
endpackage : dag_pkg

/* File: rtl/dag_top.sv */
// dual data address generator: one for data memory, one for
// program memory, both answering in the same cycle
// assumes one core clock and a decoder driving both ports
`timescale 1ns/10ps
`include "dag_cfg.svh"
module dag_top (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic bank_sel,
    input wire dag_pkg::dag_op_t dm_op,
    input wire logic [`DAG_SEL_W-1:0] dm_idx_sel,
    input wire logic [`DAG_SEL_W-1:0] dm_mod_sel,
    input wire logic [`DAG_IMM_W-1:0] dm_imm,
    input wire dag_pkg::dag_wr_t dm_wr_kind,
    input wire logic [`DAG_SEL_W-1:0] dm_wr_sel,
    input wire logic [`DAG_PTR_W-1:0] dm_wr_data,
    input wire dag_pkg::dag_op_t pm_op,
    input wire logic [`DAG_SEL_W-1:0] pm_idx_sel,
    input wire logic [`DAG_SEL_W-1:0] pm_mod_sel,
    input wire logic [`DAG_IMM_W-1:0] pm_imm,
    input wire dag_pkg::dag_wr_t pm_wr_kind,
    input wire logic [`DAG_SEL_W-1:0] pm_wr_sel,
    input wire logic [`DAG_PTR_W-1:0] pm_wr_data,
    output logic [`DAG_PAGE_W+`DAG_PTR_W-1:0] dm_addr,
    output logic dm_addr_valid,
    output logic [`DAG_PAGE_W+`DAG_PTR_W-1:0] pm_addr,
    output logic pm_addr_valid,
    output logic bank_active
);
    import dag_pkg::*;

    // ------------------------------------------------------------
    // two independent generators, same cycle
    // ------------------------------------------------------------
    dag_unit u_dm (.clk(clk), .reset_n(reset_n), .bank_sel(bank_sel),
        .op(dm_op), .idx_sel(dm_idx_sel), .mod_sel(dm_mod_sel),
        .imm(dm_imm), .wr_kind(dm_wr_kind), .wr_sel(dm_wr_sel),
        .wr_data(dm_wr_data), .addr(dm_addr),
        .addr_valid(dm_addr_valid));
    dag_unit u_pm (.clk(clk), .reset_n(reset_n), .bank_sel(bank_sel),
        .op(pm_op), .idx_sel(pm_idx_sel), .mod_sel(pm_mod_sel),
        .imm(pm_imm), .wr_kind(pm_wr_kind), .wr_sel(pm_wr_sel),
        .wr_data(pm_wr_data), .addr(pm_addr),
        .addr_valid(pm_addr_valid));

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            bank_active <= 1'b0;
        end else begin
            bank_active <= bank_sel;
        end
    end
endmodule : dag_top

/* File: tb/dag_mem_model.sv */
// memory-side stand-in that counts dual operand fetches
// assumes valid is a one-cycle pulse per access
`timescale 1ns/10ps
module dag_mem_model (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic dm_valid,
    input wire logic pm_valid,
    output logic [7:0] dual_fetches
);
    // only fetches served on both buses in one cycle are counted
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            dual_fetches <= 8'h00;
        end else if (dm_valid && pm_valid) begin
            dual_fetches <= dual_fetches + 8'h01;
        end
    end
endmodule : dag_mem_model

/* File: tb/dag_top_properties.sv */
// assertions on the address generator top ports
// assumes one core clock and async active-low reset
`timescale 1ns/10ps
module dag_chk (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic bank_sel,
    input wire dag_pkg::dag_op_t dm_op,
    input wire logic [1:0] dm_idx_sel,
    input wire logic [1:0] dm_mod_sel,
    input wire dag_pkg::dag_wr_t dm_wr_kind,
    input wire dag_pkg::dag_op_t pm_op,
    input wire logic [23:0] dm_addr,
    input wire logic dm_addr_valid,
    input wire logic pm_addr_valid,
    input wire logic bank_active
);
    import dag_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence s_noupd_twice;
        dm_op == DAG_OP_PRE_NOUPD && dm_wr_kind == DAG_WR_NONE
        ##1 dm_op == DAG_OP_PRE_NOUPD && dm_wr_kind == DAG_WR_NONE
            && $stable({dm_idx_sel, dm_mod_sel, bank_sel});
    endsequence
    AST_DM_VALID: assert property (dm_op != DAG_OP_NONE |=> dm_addr_valid)
        else $error("dm access without valid");
    AST_DM_IDLE: assert property (dm_op == DAG_OP_NONE |=> !dm_addr_valid)
        else $error("dm valid without access");
    AST_PM_VALID: assert property (pm_op != DAG_OP_NONE |=> pm_addr_valid)
        else $error("pm access without valid");
    AST_PM_IDLE: assert property (pm_op == DAG_OP_NONE |=> !pm_addr_valid)
        else $error("pm valid without access");
    AST_DUAL: assert property (dm_op != DAG_OP_NONE && pm_op != DAG_OP_NONE
        |=> dm_addr_valid && pm_addr_valid) else $error("dual fetch split");
    AST_BANK: assert property (1'b1 |=> bank_active == $past(bank_sel))
        else $error("bank indicator wrong");
    AST_NOUPD: assert property (s_noupd_twice |=> dm_addr == $past(dm_addr))
        else $error("pointer moved on no-update access");
    AST_PAGE: assert property (dm_op != DAG_OP_NONE && $past(dm_op) != DAG_OP_NONE
        && $past(dm_wr_kind) != DAG_WR_PAGE && $stable(bank_sel)
        |=> dm_addr[23:16] == $past(dm_addr[23:16])) else $error("page changed");
endmodule : dag_chk
bind dag_top dag_chk i_dag_chk (.clk, .reset_n, .bank_sel, .dm_op,
    .dm_idx_sel, .dm_mod_sel, .dm_wr_kind, .pm_op, .dm_addr,
    .dm_addr_valid, .pm_addr_valid, .bank_active);

/* File: tb/tb_top.sv */
// self-checking bench for the dual address generator
// assumes dag_top, the bound checker and the fetch model
`timescale 1ns/10ps
`define CHK(n, e, s) checked++; if ((s) !== (e)) begin bad_count++; \
    $display("[FAIL] %s exp %h got %h", n, e, s); end
module tb_top;
    import dag_pkg::*;
    typedef struct packed {
        dag_op_t op; logic [7:0] imm; logic [23:0] exp;
    } dag_row_t;
    logic clk = 1'b0, reset_n = 1'b0, bank_sel = 1'b0;
    dag_op_t dm_op = DAG_OP_NONE;
    dag_wr_t dm_wr_kind = DAG_WR_NONE;
    logic [1:0] dm_idx_sel = 2'h0, dm_mod_sel = 2'h1, dm_wr_sel = 2'h0;
    logic [7:0] dm_imm = 8'h00;
    logic [15:0] dm_wr_data = 16'h0000;
    logic [23:0] dm_addr, pm_addr;
    logic dm_addr_valid, pm_addr_valid, bank_active;
    logic [7:0] dual_fetches;
    int bad_count = 0, checked = 0;
    // buffer 0x0100..0x0107, modify 4, page 0x12: rows cross both ends
    dag_row_t rows [8] = '{'{DAG_OP_POST_MOD, 8'h00, 24'h120100},
        '{DAG_OP_POST_MOD, 8'h00, 24'h120104},
        '{DAG_OP_PRE_NOUPD, 8'h00, 24'h120104},
        '{DAG_OP_PRE_NOUPD, 8'h00, 24'h120104},
        '{DAG_OP_PRE_MOD, 8'h00, 24'h120104},
        '{DAG_OP_POST_IMM, 8'hFB, 24'h120104},
        '{DAG_OP_PRE_IMM, 8'h01, 24'h120100},
        '{DAG_OP_POST_MOD, 8'h00, 24'h120100}};
    // pm side mirrors dm so both generators must agree every cycle
    dag_top i_dag_top (.clk, .reset_n, .bank_sel, .dm_op, .dm_idx_sel,
        .dm_mod_sel, .dm_imm, .dm_wr_kind, .dm_wr_sel, .dm_wr_data,
        .pm_op(dm_op), .pm_idx_sel(dm_idx_sel), .pm_mod_sel(dm_mod_sel),
        .pm_imm(dm_imm), .pm_wr_kind(dm_wr_kind), .pm_wr_sel(dm_wr_sel),
        .pm_wr_data(dm_wr_data), .dm_addr, .dm_addr_valid, .pm_addr,
        .pm_addr_valid, .bank_active);
    dag_mem_model i_dag_mem_model (.clk, .reset_n,
        .dm_valid(dm_addr_valid), .pm_valid(pm_addr_valid), .dual_fetches);
    initial begin
        forever #2.5 clk = ~clk;
    end
    task automatic wr(input dag_wr_t k, input logic [1:0] s,
                      input logic [15:0] d);
        @(posedge clk);
        dm_wr_kind <= k;
        dm_wr_sel <= s;
        dm_wr_data <= d;
    endtask : wr
    task automatic summarize;
        if (bad_count == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : summarize
    initial begin
        repeat (500) @(posedge clk);
        bad_count++;
        summarize();
    end
    initial begin
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        wr(DAG_WR_PAGE, 2'h0, 16'h0012);
        #1;
        `CHK("reset addr", 24'h000000, dm_addr)
        wr(DAG_WR_INDEX, 2'h0, 16'h0100);
        wr(DAG_WR_MODIFY, 2'h1, 16'h0004);
        wr(DAG_WR_LENGTH, 2'h0, 16'h0008);
        wr(DAG_WR_BASE, 2'h0, 16'h0100);
        wr(DAG_WR_NONE, 2'h0, 16'h0000);
        for (int i = 0; i <= 8; i++) begin
            @(posedge clk);
            dm_op <= (i < 8) ? rows[i % 8].op : DAG_OP_NONE;
            dm_imm <= rows[i % 8].imm;
            #1;
            if (i > 0) begin
                `CHK("dm_addr", rows[i - 1].exp, dm_addr)
                `CHK("pm_addr", rows[i - 1].exp, pm_addr)
            end
        end
        // secondary set is still cleared, primary pointer must survive
        @(posedge clk);
        bank_sel <= 1'b1;
        dm_op <= DAG_OP_POST_MOD;
        @(posedge clk);
        bank_sel <= 1'b0;
        #1;
        `CHK("secondary addr", 24'h000000, dm_addr)
        `CHK("bank_active", 1'b1, bank_active)
        @(posedge clk);
        dm_op <= DAG_OP_NONE;
        #1;
        `CHK("primary addr", 24'h120104, dm_addr)
        @(posedge clk);
        #1;
        `CHK("dual fetches", 8'h0A, dual_fetches)
        // mid-run reset clears outputs at once, without a clock edge
        @(posedge clk);
        reset_n <= 1'b0;
        #1;
        `CHK("mid reset addr", 24'h000000, dm_addr)
        `CHK("mid reset valid", 1'b0, dm_addr_valid)
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        dm_op <= DAG_OP_POST_MOD;
        @(posedge clk);
        dm_op <= DAG_OP_NONE;
        #1;
        // page and pointer were both cleared by the reset
        `CHK("addr after reset", 24'h000000, dm_addr)
        summarize();
    end
endmodule : tb_top
